// *** include/flsf_defines.vh ***
`ifndef FLSF_DEFINES_VH
`define FLSF_DEFINES_VH

// Format select codes
`define FLSF_FMT_GLEG      2'h0
`define FLSF_FMT_DLEG      2'h1
`define FLSF_FMT_SSGL      2'h2
`define FLSF_FMT_TDBL      2'h3

// Operation codes
`define FLSF_OP_LOAD       1'h0
`define FLSF_OP_STORE      1'h1

// Register image field positions
`define FLSF_REG_SIGN      63
`define FLSF_REG_EXP_HI    62
`define FLSF_REG_EXP_LO    52
`define FLSF_REG_SFRAC_HI  51
`define FLSF_REG_SFRAC_LO  29

// Legacy memory word field positions
`define FLSF_LEG_SIGN      15
`define FLSF_GLEG_EXP_HI   14
`define FLSF_GLEG_EXP_LO   4
`define FLSF_DLEG_EXP_HI   14
`define FLSF_DLEG_EXP_LO   7

// Single memory field positions
`define FLSF_SSGL_SIGN     31
`define FLSF_SSGL_EXP_HI   30
`define FLSF_SSGL_EXP_LO   23

// Exponent codes and biases
`define FLSF_EXP8_ONES     8'hff
`define FLSF_EXP11_ONES    11'h7ff
`define FLSF_GLEG_BIAS     12'h400
`define FLSF_DLEG_BIAS     12'h080
`define FLSF_SSGL_BIAS     12'h07f
`define FLSF_TDBL_BIAS     12'h3ff
`define FLSF_SSGL_DEN_EXP  12'hf82
`define FLSF_TDBL_DEN_EXP  12'hc02

// Class flag bit positions
`define FLSF_CL_ZERO       0
`define FLSF_CL_DENORM     1
`define FLSF_CL_NORMAL     2
`define FLSF_CL_INF        3
`define FLSF_CL_QNAN       4
`define FLSF_CL_SNAN       5
`define FLSF_CL_RSVD       6
`define FLSF_CL_W          7

`endif

// *** src/flsf_ieee_class.v ***
`timescale 1ns/1ns
`default_nettype none

// Generic IEEE field classifier, sized by exponent and fraction width
module flsf_ieee_class #(
  parameter EW = 11,
  parameter FW = 52
) (
  input  wire [EW-1:0] exp_in,
  input  wire [FW-1:0] frac_in,
  output wire          is_zero,
  output wire          is_denorm,
  output wire          is_normal,
  output wire          is_inf,
  output wire          is_qnan,
  output wire          is_snan
);

  wire exp_zero = (exp_in == {EW{1'b0}});
  wire exp_ones = (exp_in == {EW{1'b1}});
  wire frac_nz  = (frac_in != {FW{1'b0}});

  // Field decode into operand class
  assign is_zero   = exp_zero & ~frac_nz;
  assign is_denorm = exp_zero & frac_nz;
  assign is_normal = ~exp_zero & ~exp_ones;
  assign is_inf    = exp_ones & ~frac_nz;
  assign is_qnan   = exp_ones & frac_in[FW-1];              // Top fraction bit set
  assign is_snan   = exp_ones & frac_nz & ~frac_in[FW-1];

endmodule // flsf_ieee_class

`default_nettype wire

// *** src/flsf_leg_swap.v ***
`timescale 1ns/1ns
`default_nettype none

// Reverse order of the four 16-bit words; the swap is its own inverse
module flsf_leg_swap (
  input  wire [63:0] din,
  output wire [63:0] dout
);

  assign dout = {din[15:0], din[31:16], din[47:32], din[63:48]};

endmodule // flsf_leg_swap

`default_nettype wire

// *** src/flsf_unit.v ***
`timescale 1ns/1ns
`default_nettype none
`include "flsf_defines.vh"

// Notes on behaviour
// - G legacy: sign bit 15, exponent 14:4
// - G fraction: bits 3:0 and 63:16
// - G exponent zero: sign0 zero, sign1 reserved
// - Zero results always all-zero encoding
// - G exponent codes map to -1023..1023
// - D legacy uses same reorder as G
// - D legacy: single-style layout, longer fraction
// - No D arithmetic; convert via G
// - Single load: shift up, widen exponent, clear low
// - Single exponent widening inserts 000 or 111
// - All-ones single exponent becomes all-ones
// - Single store ignores 61:59 and 28:0
// - Single load never validates its input
// - Single register image left-justified, low zero
// - Single memory: sign 31, exp 30:23
// - Single class: NaN, inf, normal, denormal, zero
// - Double loads and stores move bits unchanged
// - Double: sign 63, exp 62:52, frac 51:0
// - Double class: NaN, inf, normal, denormal, zero
// - Signaling NaN operand flags invalid operation
// - Quiet NaN operand raises nothing
// - Infinities rank beyond every finite value
// - D exponent at bits 14:7, excess-128
module flsf_unit (
  input  wire        CLK_SYS,
  input  wire        RST_B,
  input  wire        REQ_VALID,
  input  wire        REQ_OP,
  input  wire [1:0]  REQ_FMT,
  input  wire        REQ_ARITH,
  input  wire [63:0] MEM_DATA_IN,
  input  wire [63:0] REG_DATA_IN,
  input  wire        ZERO_RESULT,
  output reg         RSP_VALID,
  output reg  [63:0] REG_DATA_OUT,
  output reg  [63:0] MEM_DATA_OUT,
  output reg  [6:0]  OPND_CLASS,
  output reg         OPND_SIGN,
  output reg  [11:0] OPND_TRUE_EXP,
  output reg         INVALID_OP,
  output reg         ARITH_EXC,
  output reg         DLEG_ARITH_ERR,
  output reg  [1:0]  OPND_RANK
);

  // ************************************************************
  // Load and store paths: memory image to and from register image
  // ************************************************************

  wire [63:0] leg_swapped;
  wire [7:0]  s_mexp;
  wire [10:0] s_rexp;
  wire [63:0] s_load_img;
  wire [31:0] s_store_img;
  reg  [63:0] load_img;
  reg  [63:0] store_img;

  // Word swap for both legacy doubles
  flsf_leg_swap u_swap (
    .din  (MEM_DATA_IN),
    .dout (leg_swapped)
  );

  // Exponent widening 8 to 11 bits
  assign s_mexp = MEM_DATA_IN[`FLSF_SSGL_EXP_HI:`FLSF_SSGL_EXP_LO];
  assign s_rexp = (s_mexp == `FLSF_EXP8_ONES) ? `FLSF_EXP11_ONES :
                  (s_mexp == 8'h00)           ? 11'h000 :
                  s_mexp[7] ? {1'b1, 3'h0, s_mexp[6:0]} :
                              {1'b0, 3'h7, s_mexp[6:0]};

  // Single load image, low fraction cleared, no validation
  assign s_load_img = {MEM_DATA_IN[`FLSF_SSGL_SIGN], s_rexp,
                       MEM_DATA_IN[22:0], 29'h00000000};

  // Single store image drops 61:59 and 28:0
  assign s_store_img = {REG_DATA_IN[63:62], REG_DATA_IN[58:29]};

  // Format select for both directions
  always @* begin
    case (REQ_FMT)
      `FLSF_FMT_GLEG, `FLSF_FMT_DLEG: begin
        load_img  = leg_swapped;
        store_img = {REG_DATA_IN[15:0], REG_DATA_IN[31:16],
                     REG_DATA_IN[47:32], REG_DATA_IN[63:48]};
      end
      `FLSF_FMT_SSGL: begin
        load_img  = s_load_img;
        store_img = {32'h00000000, s_store_img};
      end
      default: begin
        load_img  = MEM_DATA_IN;
        store_img = REG_DATA_IN;
      end
    endcase
  end

  // ************************************************************
  // Operand decode on the register image
  // ************************************************************

  wire [63:0] opnd = (REQ_OP == `FLSF_OP_LOAD) ? load_img : REG_DATA_IN;
  wire        o_sign = opnd[`FLSF_REG_SIGN];
  wire [10:0] g_exp  = opnd[`FLSF_REG_EXP_HI:`FLSF_REG_EXP_LO];
  wire [51:0] g_frac = opnd[51:0];
  wire [7:0]  d_exp  = opnd[62:55];
  wire [7:0]  sm_exp = {opnd[62], opnd[58:52]};
  wire [22:0] sm_frac = opnd[`FLSF_REG_SFRAC_HI:`FLSF_REG_SFRAC_LO];

  wire s_zero, s_den, s_norm, s_inf, s_qnan, s_snan;
  wire t_zero, t_den, t_norm, t_inf, t_qnan, t_snan;

  // Single-width classifier on narrowed fields
  flsf_ieee_class #(
    .EW (8),
    .FW (23)
  ) u_s_class (
    .exp_in    (sm_exp),
    .frac_in   (sm_frac),
    .is_zero   (s_zero),
    .is_denorm (s_den),
    .is_normal (s_norm),
    .is_inf    (s_inf),
    .is_qnan   (s_qnan),
    .is_snan   (s_snan)
  );

  // Double-width classifier
  flsf_ieee_class #(
    .EW (11),
    .FW (52)
  ) u_t_class (
    .exp_in    (g_exp),
    .frac_in   (g_frac),
    .is_zero   (t_zero),
    .is_denorm (t_den),
    .is_normal (t_norm),
    .is_inf    (t_inf),
    .is_qnan   (t_qnan),
    .is_snan   (t_snan)
  );

  reg [6:0]  cls_d;
  reg [11:0] texp_d;
  reg        leg_zero_exp;

  // Class flags and unbiased exponent per format
  always @* begin
    cls_d        = 7'h00;
    texp_d       = 12'h000;
    leg_zero_exp = 1'b0;
    case (REQ_FMT)
      `FLSF_FMT_GLEG: begin
        leg_zero_exp = (g_exp == 11'h000);
        cls_d[`FLSF_CL_ZERO]   = leg_zero_exp & ~o_sign;
        cls_d[`FLSF_CL_RSVD]   = leg_zero_exp & o_sign;
        cls_d[`FLSF_CL_NORMAL] = ~leg_zero_exp;
        texp_d = {1'b0, g_exp} - `FLSF_GLEG_BIAS;
      end
      `FLSF_FMT_DLEG: begin
        leg_zero_exp = (d_exp == 8'h00);
        cls_d[`FLSF_CL_ZERO]   = leg_zero_exp & ~o_sign;
        cls_d[`FLSF_CL_RSVD]   = leg_zero_exp & o_sign;
        cls_d[`FLSF_CL_NORMAL] = ~leg_zero_exp;
        texp_d = {4'h0, d_exp} - `FLSF_DLEG_BIAS;
      end
      `FLSF_FMT_SSGL: begin
        cls_d = {1'b0, s_snan, s_qnan, s_inf, s_norm, s_den, s_zero};
        texp_d = s_den ? `FLSF_SSGL_DEN_EXP :
                 ({4'h0, sm_exp} - `FLSF_SSGL_BIAS);
      end
      default: begin
        cls_d = {1'b0, t_snan, t_qnan, t_inf, t_norm, t_den, t_zero};
        texp_d = t_den ? `FLSF_TDBL_DEN_EXP :
                 ({1'b0, g_exp} - `FLSF_TDBL_BIAS);
      end
    endcase
  end

  // Infinity ranking: 00 finite or NaN, 01 below all, 10 above all
  wire [1:0] rank_d = ~cls_d[`FLSF_CL_INF] ? 2'h0 :
                      (o_sign ? 2'h1 : 2'h2);

  // Zero result forces canonical all-zero word
  wire [63:0] reg_out_d = ZERO_RESULT ? 64'h0000000000000000 : load_img;
  wire [63:0] mem_out_d = ZERO_RESULT ? 64'h0000000000000000 : store_img;

  // ************************************************************
  // Output registers
  // ************************************************************

  // Result and flag capture on each request
  always @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      RSP_VALID      <= 1'b0;
      REG_DATA_OUT   <= 64'h0000000000000000;
      MEM_DATA_OUT   <= 64'h0000000000000000;
      OPND_CLASS     <= 7'h00;
      OPND_SIGN      <= 1'b0;
      OPND_TRUE_EXP  <= 12'h000;
      INVALID_OP     <= 1'b0;
      ARITH_EXC      <= 1'b0;
      DLEG_ARITH_ERR <= 1'b0;
      OPND_RANK      <= 2'h0;
    end else begin
      RSP_VALID <= REQ_VALID;
      if (REQ_VALID) begin
        if (REQ_OP == `FLSF_OP_LOAD) begin
          REG_DATA_OUT <= reg_out_d;
        end else begin
          MEM_DATA_OUT <= mem_out_d;
        end
        OPND_CLASS    <= cls_d;
        OPND_SIGN     <= o_sign;
        OPND_TRUE_EXP <= texp_d;
        OPND_RANK     <= rank_d;
        INVALID_OP    <= REQ_ARITH & cls_d[`FLSF_CL_SNAN];
        ARITH_EXC     <= REQ_ARITH & (cls_d[`FLSF_CL_RSVD] |
                                      cls_d[`FLSF_CL_SNAN]);
        DLEG_ARITH_ERR <= REQ_ARITH & (REQ_FMT == `FLSF_FMT_DLEG);
      end else begin
        INVALID_OP     <= 1'b0;
        ARITH_EXC      <= 1'b0;
        DLEG_ARITH_ERR <= 1'b0;
      end
    end
  end

endmodule // flsf_unit

`default_nettype wire

// *** test/flsf_unit_monitor.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************
// Unit checker
// ****************
module flsf_unit_monitor (
  input wire logic        CLK_SYS,
  input wire logic        RST_B,
  input wire logic        REQ_VALID,
  input wire logic        REQ_OP,
  input wire logic [1:0]  REQ_FMT,
  input wire logic        REQ_ARITH,
  input wire logic [63:0] MEM_DATA_IN,
  input wire logic [63:0] REG_DATA_IN,
  input wire logic        ZERO_RESULT,
  input wire logic        RSP_VALID,
  input wire logic [63:0] REG_DATA_OUT,
  input wire logic [63:0] MEM_DATA_OUT,
  input wire logic [6:0]  OPND_CLASS,
  input wire logic        INVALID_OP,
  input wire logic        ARITH_EXC,
  input wire logic        DLEG_ARITH_ERR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  // Request qualifiers and expected word images
  wire        ld   = REQ_VALID && !REQ_OP && !ZERO_RESULT;
  wire        st   = REQ_VALID && REQ_OP && !ZERO_RESULT;
  wire [63:0] mswp = {MEM_DATA_IN[15:0], MEM_DATA_IN[31:16],
                      MEM_DATA_IN[47:32], MEM_DATA_IN[63:48]};
  wire [63:0] rswp = {REG_DATA_IN[15:0], REG_DATA_IN[31:16],
                      REG_DATA_IN[47:32], REG_DATA_IN[63:48]};
  wire [31:0] sst  = {REG_DATA_IN[63:62], REG_DATA_IN[58:29]};

  chk_rsp_follows: assert property (REQ_VALID |=> RSP_VALID)
    else $error("response missing");
  chk_rsp_quiet: assert property (!REQ_VALID |=> !RSP_VALID)
    else $error("spurious response");
  chk_leg_load_swap: assert property (ld && !REQ_FMT[1]
    |=> REG_DATA_OUT == $past(mswp)) else $error("legacy load order wrong");
  chk_leg_store_swap: assert property (st && !REQ_FMT[1]
    |=> MEM_DATA_OUT == $past(rswp)) else $error("legacy store order wrong");
  chk_sgl_low_zero: assert property (ld && REQ_FMT == 2'h2
    |=> REG_DATA_OUT[28:0] == 29'h0) else $error("single low bits not cleared");
  chk_sgl_exp_ones: assert property (ld && REQ_FMT == 2'h2 && MEM_DATA_IN[30:23] == 8'hff
    |=> REG_DATA_OUT[62:52] == 11'h7ff) else $error("single all-ones exponent lost");
  chk_sgl_store_img: assert property (st && REQ_FMT == 2'h2
    |=> MEM_DATA_OUT == {32'h0, $past(sst)}) else $error("single store image wrong");
  chk_dbl_pass: assert property (ld && REQ_FMT == 2'h3
    |=> REG_DATA_OUT == $past(MEM_DATA_IN)) else $error("double load altered");
  chk_zero_canon: assert property (REQ_VALID && ZERO_RESULT
    |=> ($past(REQ_OP) ? MEM_DATA_OUT : REG_DATA_OUT) == 64'h0) else $error("zero not canonical");
  chk_snan_invalid: assert property (INVALID_OP |-> OPND_CLASS[5] && RSP_VALID)
    else $error("invalid without signaling NaN");
  chk_qnan_quiet: assert property (RSP_VALID && OPND_CLASS[4] |-> !ARITH_EXC)
    else $error("quiet NaN raised exception");
  chk_dleg_arith: assert property (REQ_VALID && REQ_ARITH && REQ_FMT == 2'h1
    |=> DLEG_ARITH_ERR) else $error("legacy D arithmetic not flagged");
  // Main scenarios seen
  cov_sgl_load: cover property (ld && REQ_FMT == 2'h2);
  cov_reserved: cover property (RSP_VALID && OPND_CLASS[6]);
  cov_leg_store: cover property (st && REQ_FMT == 2'h0);
endmodule // flsf_unit_monitor
bind flsf_unit flsf_unit_monitor mon (.CLK_SYS(CLK_SYS), .RST_B(RST_B), .REQ_VALID(REQ_VALID),
  .REQ_OP(REQ_OP), .REQ_FMT(REQ_FMT), .REQ_ARITH(REQ_ARITH), .MEM_DATA_IN(MEM_DATA_IN),
  .REG_DATA_IN(REG_DATA_IN), .ZERO_RESULT(ZERO_RESULT), .RSP_VALID(RSP_VALID),
  .REG_DATA_OUT(REG_DATA_OUT), .MEM_DATA_OUT(MEM_DATA_OUT), .OPND_CLASS(OPND_CLASS),
  .INVALID_OP(INVALID_OP), .ARITH_EXC(ARITH_EXC), .DLEG_ARITH_ERR(DLEG_ARITH_ERR));
`default_nettype wire

// *** test/flsf_fpreg_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ****************
// Floating register model
// ****************
module flsf_fpreg_model (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        req_valid,
  input  wire logic        req_op,
  input  wire logic        rsp_valid,
  input  wire logic [63:0] reg_data_out,
  output logic      [63:0] reg_data_in
);
  logic        load_q;
  logic [63:0] reg_q;
  assign reg_data_in = reg_q;
  // Keep last load result; stores only see words the unit produced
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      load_q <= 1'b0;
      reg_q <= 64'h0;
    end else begin
      if (req_valid) load_q <= !req_op;
      if (rsp_valid && load_q) reg_q <= reg_data_out;
    end
  end
endmodule // flsf_fpreg_model
`default_nettype wire

// *** test/flsf_unit_test.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s exp %h got %h", nm, e, g); end end
// ****************
// Unit bench
// ****************
module flsf_unit_test;
  logic        clk_sys = 0, rst_b = 0, req_valid = 0, req_op = 0, req_arith = 0, zero_result = 0;
  logic [1:0]  req_fmt = 0;
  logic [63:0] mem_in = 0;
  wire  [63:0] reg_in, reg_out, mem_out;
  wire  [6:0]  cls;
  wire  [11:0] texp;
  wire  [1:0]  rank;
  wire         rsp_valid, sgn, inv, aexc, derr;
  int          n_errors = 0, checks_done = 0;

  // 25 MHz clock
  always #20 clk_sys = ~clk_sys;

  flsf_unit uut (.CLK_SYS(clk_sys), .RST_B(rst_b), .REQ_VALID(req_valid), .REQ_OP(req_op),
    .REQ_FMT(req_fmt), .REQ_ARITH(req_arith), .MEM_DATA_IN(mem_in), .REG_DATA_IN(reg_in),
    .ZERO_RESULT(zero_result), .RSP_VALID(rsp_valid), .REG_DATA_OUT(reg_out),
    .MEM_DATA_OUT(mem_out), .OPND_CLASS(cls), .OPND_SIGN(sgn), .OPND_TRUE_EXP(texp),
    .INVALID_OP(inv), .ARITH_EXC(aexc), .DLEG_ARITH_ERR(derr), .OPND_RANK(rank));
  flsf_fpreg_model fpr (.clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid),
    .req_op(req_op), .rsp_valid(rsp_valid), .reg_data_out(reg_out), .reg_data_in(reg_in));

  // Expected register image of a single load
  function automatic logic [63:0] sgl(input logic [31:0] m);
    logic [10:0] e;
    e = m[30:23] == 8'hff ? 11'h7ff :
        m[30:23] == 8'h0  ? 11'h0 : {m[30], {3{~m[30]}}, m[29:23]};
    return {m[31], e, m[22:0], 29'h0};
  endfunction

  // One request, response checked at the negedge after the edge that captures it
  task automatic req(input logic op, input logic [1:0] fmt, input logic ar, input logic zr,
                     input logic [63:0] m);
    @(posedge clk_sys);
    req_valid <= 1'b1;
    req_op <= op;
    req_fmt <= fmt;
    req_arith <= ar;
    zero_result <= zr;
    mem_in <= m;
    @(posedge clk_sys);
    req_valid <= 1'b0;
    @(negedge clk_sys);
    `CHK("rsp_valid", 1'b1, rsp_valid)
  endtask

  // Load with arithmetic use, then store the result back
  task automatic xfer(input logic [1:0] fmt, input logic [63:0] m, input logic [63:0] er,
                      input logic [6:0] ec, input logic [11:0] ee);
    req(1'b0, fmt, 1'b1, 1'b0, m);
    `CHK("reg_out", er, reg_out)
    `CHK("class", ec, cls)
    `CHK("sign", er[63], sgn)
    `CHK("invalid", ec[5], inv)
    `CHK("arith_exc", (ec[5] | ec[6]), aexc)
    `CHK("dleg_err", (fmt == 2'h1), derr)
    `CHK("rank", (ec[3] ? {~er[63], er[63]} : 2'h0), rank)
    if (ec[1] | ec[2]) `CHK("true_exp", ee, texp)
    req(1'b1, fmt, 1'b0, 1'b0, 64'h0);
    `CHK("mem_out", (fmt == 2'h2 ? {32'h0, m[31:0]} : m), mem_out)
  endtask

  // Single loads across every exponent mapping and class
  task automatic t_single;
    logic [31:0] m [9] = '{32'h3f800000, 32'h7f800000, 32'hff800000, 32'h00000001, 32'h00800000,
                           32'hc0000000, 32'h7fc00000, 32'h7f800001, 32'h80000000};
    logic [6:0]  c [9] = '{7'h04, 7'h08, 7'h08, 7'h02, 7'h04, 7'h04, 7'h10, 7'h20, 7'h01};
    logic [11:0] e [9] = '{12'h0, 12'h0, 12'h0, 12'hf82, 12'hf82, 12'h001, 12'h0, 12'h0, 12'h0};
    for (int i = 0; i < 9; i++) xfer(2'h2, {32'h0, m[i]}, sgl(m[i]), c[i], e[i]);
  endtask

  // Double words pass unchanged in both directions
  task automatic t_double;
    xfer(2'h3, 64'h7ff0000000000001, 64'h7ff0000000000001, 7'h20, 12'h0);
    xfer(2'h3, 64'h7ff8000000000000, 64'h7ff8000000000000, 7'h10, 12'h0);
    xfer(2'h3, 64'hfff0000000000000, 64'hfff0000000000000, 7'h08, 12'h0);
    xfer(2'h3, 64'h0000000000000001, 64'h0000000000000001, 7'h02, 12'hc02);
    xfer(2'h3, 64'h3ff0000000000000, 64'h3ff0000000000000, 7'h04, 12'h0);
  endtask

  // Legacy words swapped, reserved and zero operands
  task automatic t_legacy;
    xfer(2'h0, 64'h1111222233334010, 64'h4010333322221111, 7'h04, 12'h001);
    xfer(2'h0, 64'h0000000000008000, 64'h8000000000000000, 7'h40, 12'h0);
    xfer(2'h0, 64'h0, 64'h0, 7'h01, 12'h0);
    xfer(2'h1, 64'h5555666677774080, 64'h4080777766665555, 7'h04, 12'h001);
  endtask

  // Forced zero result in both directions
  task automatic t_zero;
    req(1'b1, 2'h1, 1'b0, 1'b1, 64'h0);
    `CHK("zero_store", 64'h0, mem_out)
    req(1'b0, 2'h3, 1'b0, 1'b1, 64'hbff0000000000000);
    `CHK("zero_load", 64'h0, reg_out)
  endtask

  // Verdict and end of run
  task automatic complete_run;
    if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_single();
    t_double();
    t_legacy();
    t_zero();
    complete_run();
  end
endmodule // flsf_unit_test
`default_nettype wire
